// ### rtl/dtc_timer.sv
`timescale 1ns/100ps
module dtc_timer
    import dtc_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [DTC_AW-1:0] reg_addr,
    input wire logic [DTC_DW-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DTC_DW-1:0] reg_rdata,
    input wire logic count_pin0,
    input wire logic count_pin1,
    input wire logic external_gate_pin0,
    input wire logic external_gate_pin1,
    input wire logic vector0_ack,
    input wire logic vector1_ack,
    output logic counter0_overflow_flag,
    output logic counter1_overflow_flag,
    output logic irq
);

    // ==========================================================
    // helpers
    // ==========================================================
    function automatic logic hit(input logic [DTC_AW-1:0] a, input logic [DTC_AW-1:0] off);
        return a == off;
    endfunction

    // one increment of a counter pair: returns {carry out, high, low}
    function automatic logic [16:0] cnt_step(input dtc_mode_t m, input logic [7:0] lo,
                                             input logic [7:0] hi);
        logic [16:0] r;
        logic [5:0] pre;
        logic [8:0] hsum;
        r = {1'b0, hi, lo};
        pre = {1'b0, lo[4:0]} + 6'h01;
        hsum = {1'b0, hi} + 9'h001;
        unique case (m)
            DTC_MODE_13BIT: begin
                // upper three low-byte bits are left alone
                r = {1'b0, hi, lo[7:5], pre[4:0]};
                if (pre[5]) begin
                    r = {hsum, lo[7:5], pre[4:0]};
                end
            end
            DTC_MODE_16BIT: begin
                r = {1'b0, hi, lo} + 17'h00001;
            end
            DTC_MODE_RELOAD: begin
                r = (lo == 8'hff) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
            end
            DTC_MODE_SPLIT: begin
                r = {lo == 8'hff, hi, lo + 8'h01};
            end
        endcase
        return r;
    endfunction

    // ==========================================================
    // peripheral cycle and pin sampling
    // ==========================================================
    logic tick;
    logic [3:0] pin_vec;
    logic [3:0] pin_level;
    logic [3:0] pin_fall;

    dtc_cycle_tick u_tick (
        .clock(clock),
        .reset_n(reset_n),
        .tick(tick)
    );

    assign pin_vec = {external_gate_pin1, external_gate_pin0, count_pin1, count_pin0};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            dtc_pin_sampler u_smp (
                .clock(clock),
                .reset_n(reset_n),
                .pin(pin_vec[gi]),
                .tick(tick),
                .level(pin_level[gi]),
                .fall(pin_fall[gi])
            );
        end
    endgenerate

    // ==========================================================
    // registers
    // ==========================================================
    logic [7:0] mode_reg;
    logic [7:0] mode_next;
    logic run0_reg;
    logic run0_next;
    logic run1_reg;
    logic run1_next;
    logic flag0_reg;
    logic flag0_next;
    logic flag1_reg;
    logic flag1_next;
    logic [7:0] low0_reg;
    logic [7:0] low0_next;
    logic [7:0] high0_reg;
    logic [7:0] high0_next;
    logic [7:0] low1_reg;
    logic [7:0] low1_next;
    logic [7:0] high1_reg;
    logic [7:0] high1_next;
    logic [1:0] irq_status_reg;
    logic [1:0] irq_status_next;
    logic [1:0] irq_mask_reg;
    logic [1:0] irq_mask_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // ==========================================================
    // mode field decode
    // ==========================================================
    dtc_mode_t mode0;
    dtc_mode_t mode1;
    logic src0;
    logic src1;
    logic gate_enable_bit;
    logic gate1;
    logic split0;

    assign mode0 = dtc_mode_t'(mode_reg[DTC_MODE_LOW_BIT +: 2]);
    assign mode1 = dtc_mode_t'(mode_reg[DTC_MODE_CNT1_SHIFT + DTC_MODE_LOW_BIT +: 2]);
    assign src0 = mode_reg[DTC_SRC_BIT];
    assign src1 = mode_reg[DTC_MODE_CNT1_SHIFT + DTC_SRC_BIT];
    assign gate_enable_bit = mode_reg[DTC_GATE_BIT];
    assign gate1 = mode_reg[DTC_MODE_CNT1_SHIFT + DTC_GATE_BIT];
    assign split0 = (mode0 == DTC_MODE_SPLIT);

    // ==========================================================
    // count enables
    // ==========================================================
    logic gate_ok0;
    logic gate_ok1;
    logic inc0;
    logic inc1;
    logic inc_high0;

    assign gate_ok0 = ~gate_enable_bit | pin_level[2];
    assign gate_ok1 = ~gate1 | pin_level[3];
    assign inc0 = run0_reg & gate_ok0 & (src0 ? pin_fall[0] : tick);
    // counter 1 holds in mode 3
    assign inc1 = run1_reg & gate_ok1 & (src1 ? pin_fall[1] : tick)
                  & (mode1 != DTC_MODE_SPLIT);
    // split high half: peripheral cycles only, run by counter 1's run bit
    assign inc_high0 = split0 & run1_reg & tick;

    logic [16:0] step0;
    logic [16:0] step1;
    logic set_flag0;
    logic set_flag1;

    assign step0 = cnt_step(mode0, low0_reg, high0_reg);
    assign step1 = cnt_step(mode1, low1_reg, high1_reg);
    assign set_flag0 = inc0 & step0[16];
    // with counter 0 split, counter 1 loses its flag to the high half
    assign set_flag1 = split0 ? (inc_high0 & (high0_reg == 8'hff))
                              : (inc1 & step1[16]);

    // ==========================================================
    // register port decode
    // ==========================================================
    logic wr_mode;
    logic wr_ctrl;
    logic wr_low0;
    logic wr_high0;
    logic wr_low1;
    logic wr_high1;
    logic wr_status;
    logic wr_mask;

    assign wr_mode = reg_write & hit(reg_addr, DTC_OFF_MODE);
    assign wr_ctrl = reg_write & hit(reg_addr, DTC_OFF_CTRL);
    assign wr_low0 = reg_write & hit(reg_addr, DTC_OFF_LOW0);
    assign wr_high0 = reg_write & hit(reg_addr, DTC_OFF_HIGH0);
    assign wr_low1 = reg_write & hit(reg_addr, DTC_OFF_LOW1);
    assign wr_high1 = reg_write & hit(reg_addr, DTC_OFF_HIGH1);
    assign wr_status = reg_write & hit(reg_addr, DTC_OFF_IRQ_STATUS);
    assign wr_mask = reg_write & hit(reg_addr, DTC_OFF_IRQ_MASK);

    // ==========================================================
    // next values
    // ==========================================================
    // a preset while running is the caller's hazard: the write simply wins
    assign low0_next = wr_low0 ? reg_wdata : (inc0 ? step0[7:0] : low0_reg);
    assign high0_next = wr_high0 ? reg_wdata
                      : split0 ? (inc_high0 ? high0_reg + 8'h01 : high0_reg)
                      : (inc0 ? step0[15:8] : high0_reg);
    assign low1_next = wr_low1 ? reg_wdata : (inc1 ? step1[7:0] : low1_reg);
    assign high1_next = wr_high1 ? reg_wdata : (inc1 ? step1[15:8] : high1_reg);
    assign mode_next = wr_mode ? reg_wdata : mode_reg;

    // run bits only gate counting; the bytes are not touched
    assign run0_next = wr_ctrl ? reg_wdata[DTC_RUN0_BIT] : run0_reg;
    assign run1_next = wr_ctrl ? reg_wdata[DTC_RUN1_BIT] : run1_reg;

    // hardware set beats a vector acknowledge or a software write of zero
    assign flag0_next = set_flag0 | (wr_ctrl ? reg_wdata[DTC_FLAG0_BIT]
                                             : (flag0_reg & ~vector0_ack));
    assign flag1_next = set_flag1 | (wr_ctrl ? reg_wdata[DTC_FLAG1_BIT]
                                             : (flag1_reg & ~vector1_ack));

    assign irq_status_next = {set_flag1, set_flag0}
                           | (irq_status_reg & ~(wr_status ? reg_wdata[1:0] : 2'h0));
    assign irq_mask_next = wr_mask ? reg_wdata[1:0] : irq_mask_reg;

    // ==========================================================
    // read path: data stand only in the cycle after the strobe
    // ==========================================================
    logic [7:0] ctrl_view;
    logic [7:0] rd_mux;

    assign ctrl_view = {flag1_reg, run1_reg, flag0_reg, run0_reg, 4'h0};
    assign rd_mux = hit(reg_addr, DTC_OFF_MODE) ? mode_reg
                  : hit(reg_addr, DTC_OFF_CTRL) ? ctrl_view
                  : hit(reg_addr, DTC_OFF_LOW0) ? low0_reg
                  : hit(reg_addr, DTC_OFF_HIGH0) ? high0_reg
                  : hit(reg_addr, DTC_OFF_LOW1) ? low1_reg
                  : hit(reg_addr, DTC_OFF_HIGH1) ? high1_reg
                  : hit(reg_addr, DTC_OFF_IRQ_STATUS) ? {6'h00, irq_status_reg}
                  : {6'h00, irq_mask_reg};
    assign rdata_next = reg_read ? rd_mux : 8'h00;

    // ==========================================================
    // state
    // ==========================================================
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            mode_reg <= DTC_RST_BYTE;
            run0_reg <= 1'b0;
            run1_reg <= 1'b0;
            flag0_reg <= 1'b0;
            flag1_reg <= 1'b0;
            low0_reg <= DTC_RST_BYTE;
            high0_reg <= DTC_RST_BYTE;
            low1_reg <= DTC_RST_BYTE;
            high1_reg <= DTC_RST_BYTE;
            irq_status_reg <= DTC_RST_IRQ;
            irq_mask_reg <= DTC_RST_IRQ;
            rdata_reg <= DTC_RST_BYTE;
        end else begin
            mode_reg <= mode_next;
            run0_reg <= run0_next;
            run1_reg <= run1_next;
            flag0_reg <= flag0_next;
            flag1_reg <= flag1_next;
            low0_reg <= low0_next;
            high0_reg <= high0_next;
            low1_reg <= low1_next;
            high1_reg <= high1_next;
            irq_status_reg <= irq_status_next;
            irq_mask_reg <= irq_mask_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign counter0_overflow_flag = flag0_reg;
    assign counter1_overflow_flag = flag1_reg;
    assign irq = |(irq_status_reg & irq_mask_reg);

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    logic no_cnt_wr;
    assign no_cnt_wr = ~(wr_low0 | wr_high0 | wr_low1 | wr_high1);

    a_tick_period: assert property (
        tick |=> !tick [*5] ##1 tick)
        else $error("peripheral cycle is not six clocks");

    a_stopped_hold: assert property (
        !run0_reg && !split0 && no_cnt_wr |=> $stable(low0_reg) && $stable(high0_reg))
        else $error("counter 0 moved while stopped");

    a_mode1_carry: assert property (
        mode0 == DTC_MODE_16BIT && inc0 && low0_reg == 8'hff && no_cnt_wr
        |=> low0_reg == 8'h00 && high0_reg == $past(high0_reg) + 8'h01)
        else $error("low byte carry did not reach high byte");

    a_ovf_flag_set: assert property (
        mode0 == DTC_MODE_16BIT && inc0 && {high0_reg, low0_reg} == 16'hffff && no_cnt_wr
        |=> flag0_reg && irq_status_reg[0] && {high0_reg, low0_reg} == 16'h0000)
        else $error("rollover did not raise counter 0 flag");

    a_mode2_reload: assert property (
        mode0 == DTC_MODE_RELOAD && inc0 && low0_reg == 8'hff && no_cnt_wr
        |=> low0_reg == $past(high0_reg) && $stable(high0_reg) && flag0_reg)
        else $error("reload from high byte failed");

    a_gate_pause: assert property (
        run0_reg && gate_enable_bit && !pin_level[2] && !split0 && no_cnt_wr
        |=> $stable(low0_reg) && $stable(high0_reg))
        else $error("gated counter advanced with gate low");

    a_vector_clear: assert property (
        vector0_ack && !set_flag0 && !wr_ctrl |=> !flag0_reg)
        else $error("vector acknowledge did not clear flag");

    a_edge_count: assert property (
        mode0 == DTC_MODE_16BIT && src0 && run0_reg && !gate_enable_bit && pin_fall[0]
        && low0_reg != 8'hff && no_cnt_wr |=> low0_reg == $past(low0_reg) + 8'h01)
        else $error("falling edge not counted");

    a_split_hold: assert property (
        mode1 == DTC_MODE_SPLIT && no_cnt_wr |=> $stable(low1_reg) && $stable(high1_reg))
        else $error("counter 1 moved in hold mode");

    c_ovf0: cover property (set_flag0 ##1 irq);
    c_split_high: cover property (split0 && set_flag1);
    c_reload: cover property (mode0 == DTC_MODE_RELOAD && set_flag0);
    c_edge: cover property (src0 && inc0);

endmodule

// ### rtl/dtc_pkg.sv
package dtc_pkg;

    // ==========================================================
    // register port
    // ==========================================================
    localparam int DTC_AW = 3;
    localparam int DTC_DW = 8;

    localparam logic [2:0] DTC_OFF_MODE = 3'h0;
    localparam logic [2:0] DTC_OFF_CTRL = 3'h1;
    localparam logic [2:0] DTC_OFF_LOW0 = 3'h2;
    localparam logic [2:0] DTC_OFF_HIGH0 = 3'h3;
    localparam logic [2:0] DTC_OFF_LOW1 = 3'h4;
    localparam logic [2:0] DTC_OFF_HIGH1 = 3'h5;
    localparam logic [2:0] DTC_OFF_IRQ_STATUS = 3'h6;
    localparam logic [2:0] DTC_OFF_IRQ_MASK = 3'h7;

    // ==========================================================
    // counter_mode_register fields (counter 1 sits four bits up)
    // ==========================================================
    localparam int DTC_MODE_LOW_BIT = 0;
    localparam int DTC_SRC_BIT = 2;
    localparam int DTC_GATE_BIT = 3;
    localparam int DTC_MODE_CNT1_SHIFT = 4;

    // ==========================================================
    // counter_control_register fields
    // ==========================================================
    localparam int DTC_RUN0_BIT = 4;
    localparam int DTC_FLAG0_BIT = 5;
    localparam int DTC_RUN1_BIT = 6;
    localparam int DTC_FLAG1_BIT = 7;

    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic [7:0] DTC_RST_BYTE = 8'h00;
    localparam logic [1:0] DTC_RST_IRQ = 2'h0;

    // ==========================================================
    // timing: one peripheral cycle is six peripheral clock periods
    // ==========================================================
    localparam int DTC_CLK_PERIOD_NS = 4;
    localparam int DTC_PER_CYCLE_PERIODS = 6;
    localparam int DTC_PER_CYCLE_NS = DTC_PER_CYCLE_PERIODS * DTC_CLK_PERIOD_NS;
    localparam int DTC_TICK_CLKS = DTC_PER_CYCLE_NS / DTC_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        DTC_MODE_13BIT = 2'b00,
        DTC_MODE_16BIT = 2'b01,
        DTC_MODE_RELOAD = 2'b10,
        DTC_MODE_SPLIT = 2'b11
    } dtc_mode_t;

endpackage

// ### rtl/dtc_cycle_tick.sv
`timescale 1ns/100ps
module dtc_cycle_tick
    import dtc_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    output logic tick
);

    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;

    assign tick = (cnt_reg == 3'(DTC_TICK_CLKS - 1));
    assign cnt_next = tick ? 3'h0 : cnt_reg + 3'h1;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            cnt_reg <= 3'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

endmodule

// ### rtl/dtc_pin_sampler.sv
`timescale 1ns/100ps
module dtc_pin_sampler
    import dtc_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic pin,
    input wire logic tick,
    output logic level,
    output logic fall
);

    logic sync1_reg;
    logic sync2_reg;
    logic sample_reg;
    logic fall_reg;

    // ==========================================================
    // two-flop synchroniser, then one sample per peripheral cycle
    // ==========================================================
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sample_reg <= 1'b0;
            fall_reg <= 1'b0;
        end else begin
            sync1_reg <= pin;
            sync2_reg <= sync1_reg;
            if (tick) begin
                sample_reg <= sync2_reg;
            end
            // high in one sample, low in the next
            fall_reg <= tick & sample_reg & ~sync2_reg;
        end
    end

    assign level = sample_reg;
    assign fall = fall_reg;

endmodule

// ### tb/dtc_pin_model.sv
`timescale 1ns/100ps
// ==========================================================
// far side: drives falling edges on one external count pin
// ==========================================================
module dtc_pin_model (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [3:0] edges,
    input wire logic [4:0] hold,
    output logic pin,
    output logic busy
);
    logic [4:0] timer_reg;
    logic [4:0] left_reg;

    // idle level is high, as a pulled-up pin would rest
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pin <= 1'b1;
            busy <= 1'b0;
            timer_reg <= 5'h00;
            left_reg <= 5'h00;
        end else if (start && !busy) begin
            pin <= 1'b0;
            busy <= 1'b1;
            left_reg <= {edges, 1'b0} - 5'h01;
            timer_reg <= hold - 5'h01;
        end else if (busy) begin
            if (timer_reg != 5'h00) begin
                timer_reg <= timer_reg - 5'h01;
            end else if (left_reg == 5'h00) begin
                busy <= 1'b0;
            end else begin
                // each level stands hold clocks, never fewer than one peripheral cycle
                pin <= ~pin;
                left_reg <= left_reg - 5'h01;
                timer_reg <= hold - 5'h01;
            end
        end
    end
endmodule

// ### tb/tb_dual_timer_event_counter.sv
`timescale 1ns/100ps
module tb_dual_timer_event_counter
    import dtc_pkg::*;
;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [DTC_AW-1:0] reg_addr = 3'h0;
    logic [DTC_DW-1:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [DTC_DW-1:0] reg_rdata;
    logic gate_pin0 = 1'b0;
    logic gate_pin1 = 1'b0;
    logic ack0 = 1'b0;
    logic ack1 = 1'b0;
    logic flag0;
    logic flag1;
    logic irq;
    logic pin0;
    logic pin1;
    logic busy0;
    logic busy1;
    logic ev_start = 1'b0;
    logic [7:0] rd;
    int fail_count = 0;
    int tests_run = 0;

    initial begin
        forever #2 clock = ~clock;
    end

    dtc_timer u_dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .count_pin0(pin0), .count_pin1(pin1),
        .external_gate_pin0(gate_pin0), .external_gate_pin1(gate_pin1),
        .vector0_ack(ack0), .vector1_ack(ack1), .counter0_overflow_flag(flag0),
        .counter1_overflow_flag(flag1), .irq(irq));
    dtc_pin_model u_src0 (.clock(clock), .reset_n(reset_n), .start(ev_start),
        .edges(4'h4), .hold(5'h06), .pin(pin0), .busy(busy0));
    dtc_pin_model u_src1 (.clock(clock), .reset_n(reset_n), .start(ev_start),
        .edges(4'h3), .hold(5'h0f), .pin(pin1), .busy(busy1));

    // ==========================================================
    // bus and compare helpers
    // ==========================================================
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic rdreg(input logic [2:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask

    task automatic rdchk(input string name, input logic [2:0] a, input logic [7:0] exp);
        rdreg(a);
        check(name, rd, exp);
    endtask

    // counts are only preset with the counter stopped; run is cleared first
    task automatic preset(input logic [7:0] m, input logic [7:0] lo, input logic [7:0] hi);
        wr(DTC_OFF_CTRL, 8'h00);
        wr(DTC_OFF_MODE, m);
        wr(DTC_OFF_LOW0, lo);
        wr(DTC_OFF_HIGH0, hi);
        wr(DTC_OFF_IRQ_STATUS, 8'h03);
    endtask

    // run bit active for exactly w clock edges, one tick per six
    task automatic run_window(input logic [7:0] run_v, input logic [7:0] stop_v, input int w);
        wr(DTC_OFF_CTRL, run_v);
        repeat (w - 2) @(posedge clock);
        wr(DTC_OFF_CTRL, stop_v);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic t_reset();
        for (int i = 0; i < 8; i++) begin
            rdchk("reset value", 3'(i), 8'h00);
        end
    endtask

    task automatic t_timer_rate();
        preset(8'h01, 8'h00, 8'h00);
        run_window(8'h10, 8'h00, 60);
        rdchk("timer low", DTC_OFF_LOW0, 8'h0a);
        rdchk("timer high", DTC_OFF_HIGH0, 8'h00);
    endtask

    task automatic t_overflow();
        preset(8'h01, 8'hfe, 8'hff);
        wr(DTC_OFF_IRQ_MASK, 8'h00);
        // flag is looked at before the stop write, which would set it by itself
        wr(DTC_OFF_CTRL, 8'h10);
        repeat (16) @(posedge clock);
        #1;
        // sixteen running edges always hold the second tick, the wrap
        check("flag0 out", 8'(flag0), 8'h01);
        check("irq masked", 8'(irq), 8'h00);
        // stop keeps the flag; eighteen running edges in all, three ticks
        wr(DTC_OFF_CTRL, 8'h20);
        rdchk("wrap low", DTC_OFF_LOW0, 8'h01);
        rdchk("wrap high", DTC_OFF_HIGH0, 8'h00);
        rdchk("status", DTC_OFF_IRQ_STATUS, 8'h01);
        rdchk("control", DTC_OFF_CTRL, 8'h20);
        wr(DTC_OFF_IRQ_MASK, 8'h01);
        #1;
        check("irq unmasked", 8'(irq), 8'h01);
        @(posedge clock);
        ack0 <= 1'b1;
        @(posedge clock);
        ack0 <= 1'b0;
        #1;
        check("flag0 after vector", 8'(flag0), 8'h00);
        check("irq sticky", 8'(irq), 8'h01);
        wr(DTC_OFF_IRQ_STATUS, 8'h01);
        #1;
        check("irq cleared", 8'(irq), 8'h00);
    endtask

    task automatic t_modes();
        preset(8'h00, 8'hff, 8'h00);
        run_window(8'h10, 8'h00, 6);
        rdchk("m0 low", DTC_OFF_LOW0, 8'he0);
        rdchk("m0 high", DTC_OFF_HIGH0, 8'h01);
        preset(8'h02, 8'hff, 8'h80);
        run_window(8'h10, 8'h20, 6);
        rdchk("m2 low", DTC_OFF_LOW0, 8'h80);
        rdchk("m2 high", DTC_OFF_HIGH0, 8'h80);
        rdchk("m2 status", DTC_OFF_IRQ_STATUS, 8'h01);
        preset(8'h33, 8'h10, 8'hff);
        wr(DTC_OFF_LOW1, 8'h55);
        run_window(8'h40, 8'h80, 6);
        rdchk("m3 high half", DTC_OFF_HIGH0, 8'h00);
        rdchk("m3 low half", DTC_OFF_LOW0, 8'h10);
        rdchk("m3 hold c1", DTC_OFF_LOW1, 8'h55);
        rdchk("m3 status", DTC_OFF_IRQ_STATUS, 8'h02);
        // counter 1 flag is left set by the stop write; the vector must clear it
        @(posedge clock);
        ack1 <= 1'b1;
        @(posedge clock);
        ack1 <= 1'b0;
        #1;
        check("flag1 after vector", 8'(flag1), 8'h00);
    endtask

    task automatic t_gate();
        preset(8'h09, 8'h20, 8'h00);
        wr(DTC_OFF_CTRL, 8'h10);
        repeat (30) @(posedge clock);
        rdchk("gated hold", DTC_OFF_LOW0, 8'h20);
        @(posedge clock);
        gate_pin0 <= 1'b1;
        repeat (40) @(posedge clock);
        wr(DTC_OFF_CTRL, 8'h00);
        rdreg(DTC_OFF_LOW0);
        check("gated run", 8'(rd > 8'h20), 8'h01);
        @(posedge clock);
        gate_pin0 <= 1'b0;
    endtask

    task automatic t_events();
        int n;
        preset(8'h55, 8'h00, 8'h00);
        wr(DTC_OFF_LOW1, 8'h00);
        wr(DTC_OFF_HIGH1, 8'h00);
        wr(DTC_OFF_CTRL, 8'h50);
        @(posedge clock);
        ev_start <= 1'b1;
        @(posedge clock);
        ev_start <= 1'b0;
        n = 0;
        @(posedge clock);
        while ((busy0 === 1'b1 || busy1 === 1'b1) && n < 300) begin
            @(posedge clock);
            n++;
        end
        if (n >= 300) begin
            fail_count++;
            $display("[FAIL] event source wait expected done seen busy");
            test_done();
        end
        repeat (24) @(posedge clock);
        wr(DTC_OFF_CTRL, 8'h00);
        rdchk("edges c0", DTC_OFF_LOW0, 8'h04);
        rdchk("edges c1", DTC_OFF_LOW1, 8'h03);
    endtask

    initial begin
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        t_reset();
        t_timer_rate();
        t_overflow();
        t_modes();
        t_gate();
        t_events();
        test_done();
    end
endmodule
